/* rtl/cvf_pkg.sv */
// Constants shared by the voice filter block: register map, field layout,
// reset values, timing and the arithmetic engine's types.
// Assumes a single 100 MHz bus clock and an AHB-Lite master on the register port.
package cvf_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_HZ = 32_000;
    localparam int TICK_CYC = CLK_HZ / SAMPLE_HZ;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
    // Transmit slot every fourth sample tick (8 kHz frame)
    localparam logic [1:0] SLOT_LAST = 2'h3;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_OPCOND = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_IMPSCALE = 8'h0c;
    localparam logic [7:0] ADDR_RXPOLE = 8'h10;
    localparam logic [7:0] ADDR_TXGAIN = 8'h14;
    localparam logic [7:0] ADDR_TXSAMPLE = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;

    // ------------------------------------------------------------------
    // Operating-condition bit positions
    // ------------------------------------------------------------------
    localparam int BIT_TX_CUTOFF = 0;
    localparam int BIT_RX_CUTOFF = 1;
    localparam int BIT_HP_BYPASS = 2;
    localparam int BIT_RX_GDROP = 3;
    localparam int BIT_IRQ_ARM = 4;
    localparam int BIT_IF_LOOP = 5;
    localparam int BIT_FD_LOOP = 6;
    localparam int BIT_SA_LOOP = 7;
    localparam int BIT_TONE = 8;
    localparam int OPCOND_W = 9;
    localparam logic [OPCOND_W-1:0] OPCOND_RST = 9'h000;

    // ------------------------------------------------------------------
    // Command and coefficient layout
    // ------------------------------------------------------------------
    localparam logic [6:0] CMD_IIR_Z = 7'h4d;
    localparam int COEF_BYTES = 5;
    localparam logic [2:0] LAST_BYTE = 3'h4;
    localparam logic [39:0] RST_BYTES = 40'h01_90_90_01_90;
    localparam logic [15:0] RST_COEF = 16'h0190;
    localparam logic [4:0] IMPSCALE_RST = 5'h00;
    localparam logic [4:0] IMPSCALE_FDL = 5'h10;
    localparam logic [2:0] DIG_FULL = 3'h4;
    localparam logic [2:0] DIG_POST = 3'h2;

    // ------------------------------------------------------------------
    // Engine
    // ------------------------------------------------------------------
    localparam int DW = 20;
    typedef enum logic {ENG_IDLE, ENG_RUN} cvf_eng_t;
    typedef enum logic [2:0] {MUL_RXPOLE, MUL_Z5, MUL_Z7, MUL_Z6, MUL_GX} cvf_mul_t;

endpackage

/* rtl/cvf_voice_filter.sv */
// Voice channel filter: impedance recursive section with serial CSD multiply,
// receive DC-blocking pole, transmit gain, test states and loopbacks.
// Assumes sample inputs come from logic on hclk; one AHB-Lite master, no wait states.
`timescale 1ns/10ps

// How it works
// - Command 9A/9B moves five recursive coefficient bytes
// - Sign bit 0 means plus, 1 minus
// - Impedance filter runs at 32 kHz
// - Reset loads coefficient pairs with 0190
// - Input scaled by 1/scale, output by scale
// - Scale factor uses only two digits
// - Digit is sign bit plus 3-bit shift
// - Shift field is plain binary 0 to 7
// - Shifts and signs accumulate digit to digit
// - Multiply by shift and accumulate only
// - Up to four digits per coefficient
// - Transmit gain is one plus coefficient
// - Single pole; receive adds first difference
// - Transmit cutoff floats output, drops slot
// - Receive cutoff zeroes receive, blocks tone, loopback
// - Bypass disables transmit high-pass filtering
// - Gain drop adds 6.02 dB receive loss
// - Armed interrupt per sample, cleared on read
// - Interface loopback replaces transmit data
// - Full loopback mutes output, feeds transmit
// - Test tone replaces receive signal
module cvf_voice_filter
    import cvf_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Receive side samples
    input wire logic signed [15:0] rx_pcm_in,
    output logic signed [15:0] analog_out,
    output logic analog_out_en,
    // Transmit side samples
    input wire logic signed [15:0] analog_in,
    output logic signed [15:0] pcm_transmit_out,
    output logic pcm_transmit_out_oe,
    output logic transmit_slot_strobe_n,
    output logic transmit_slot_strobe_oe,
    // Transmit sample interrupt
    output logic tx_sample_irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic signed [DW-1:0] sx(input logic signed [15:0] v);
        sx = {{(DW-16){v[15]}}, v};
    endfunction
    function automatic logic signed [15:0] sat(input logic signed [DW-1:0] v);
        sat = v > sx(16'sh7fff) ? 16'sh7fff : v < sx(-16'sh7fff) ? -16'sh7fff : v[15:0];
    endfunction
    // One quarter of a 1 kHz sine at 32 kHz, quarter-wave table; index never passes 8
    localparam logic signed [15:0] TONE_Q [9] = '{16'sh0000, 16'sh08d4, 16'sh1151, 16'sh1925,
        16'sh2000, 16'sh25a1, 16'sh29cf, 16'sh2c62, 16'sh2d41};

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic dp_wr_r;
    logic [7:0] dp_addr_r;
    logic [31:0] hrdata_r;
    logic [OPCOND_W-1:0] opcond_r;
    logic [4:0] impscale_r;
    logic [15:0] rxpole_r;
    logic [15:0] txgain_r;
    logic [7:0] coef_r [COEF_BYTES];
    logic cmd_act_r;
    logic cmd_rd_r;
    logic [2:0] cnt_r;
    logic irq_r;
    logic signed [15:0] pcm_out_r;

    wire logic ahb_go = hsel && hready && htrans[1];
    wire logic in_map = haddr[31:8] == 24'h0;
    wire logic rd_go = ahb_go && !hwrite && in_map;
    wire logic wr_opcond = dp_wr_r && dp_addr_r == ADDR_OPCOND;
    wire logic wr_cmd = dp_wr_r && dp_addr_r == ADDR_CMD;
    wire logic wr_data = dp_wr_r && dp_addr_r == ADDR_DATA && cmd_act_r && !cmd_rd_r;
    wire logic wr_imp = dp_wr_r && dp_addr_r == ADDR_IMPSCALE;
    wire logic wr_pole = dp_wr_r && dp_addr_r == ADDR_RXPOLE;
    wire logic wr_gain = dp_wr_r && dp_addr_r == ADDR_TXGAIN;
    wire logic rd_data = rd_go && haddr[7:0] == ADDR_DATA && cmd_act_r && cmd_rd_r;
    wire logic rd_sample = rd_go && haddr[7:0] == ADDR_TXSAMPLE;
    wire logic byte_step = wr_data || rd_data;
    wire logic cmd_ok = hwdata[7:1] == CMD_IIR_Z;
    wire logic [7:0] cur_byte = coef_r[cnt_r];
    wire logic [31:0] rd_mux =
        haddr[7:0] == ADDR_OPCOND ? {23'h0, opcond_r} :
        haddr[7:0] == ADDR_CMD ? {24'h0, CMD_IIR_Z, cmd_rd_r} :
        rd_data ? {24'h0, cur_byte} :
        haddr[7:0] == ADDR_IMPSCALE ? {27'h0, impscale_r} :
        haddr[7:0] == ADDR_RXPOLE ? {16'h0, rxpole_r} :
        haddr[7:0] == ADDR_TXGAIN ? {16'h0, txgain_r} :
        rd_sample ? {16'h0, pcm_out_r} :
        haddr[7:0] == ADDR_STATUS ? {27'h0, cnt_r, cmd_act_r, irq_r} : 32'h0;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r <= 32'h0;
        end else begin
            dp_wr_r <= ahb_go && hwrite && in_map && hsize == 3'h2;
            dp_addr_r <= haddr[7:0];
            hrdata_r <= rd_go ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opcond_r <= OPCOND_RST;
            impscale_r <= IMPSCALE_RST;
            rxpole_r <= RST_COEF;
            txgain_r <= RST_COEF;
        end else begin
            if (wr_opcond) opcond_r <= hwdata[OPCOND_W-1:0];
            if (wr_imp) impscale_r <= hwdata[4:0];
            if (wr_pole) rxpole_r <= hwdata[15:0];
            if (wr_gain) txgain_r <= hwdata[15:0];
        end
    end

    // Only the recursive bytes live here; the non-recursive taps are untouched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < COEF_BYTES; i++) begin
                coef_r[i] <= RST_BYTES[39-8*i -: 8];
            end
            cmd_act_r <= 1'b0;
            cmd_rd_r <= 1'b0;
            cnt_r <= 3'h0;
        end else if (wr_cmd) begin
            cmd_act_r <= cmd_ok;
            cmd_rd_r <= hwdata[0];
            cnt_r <= 3'h0;
        end else if (byte_step) begin
            if (wr_data) coef_r[cnt_r] <= hwdata[7:0];
            cnt_r <= cnt_r == LAST_BYTE ? 3'h0 : cnt_r + 3'h1;
            cmd_act_r <= cnt_r != LAST_BYTE;
        end
    end

    // ------------------------------------------------------------------
    // Sample rate divider
    // ------------------------------------------------------------------
    logic [11:0] tick_cnt_r;
    logic [1:0] slot_cnt_r;
    logic [4:0] tone_idx_r;
    wire logic tick = tick_cnt_r == TICK_LAST;
    wire logic tx_cut = opcond_r[BIT_TX_CUTOFF];
    wire logic tx_event = tick && slot_cnt_r == SLOT_LAST && !tx_cut;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_r <= 12'h000;
            slot_cnt_r <= 2'h0;
            tone_idx_r <= 5'h00;
        end else begin
            tick_cnt_r <= tick ? 12'h000 : tick_cnt_r + 12'h001;
            if (tick) slot_cnt_r <= slot_cnt_r + 2'h1;
            if (tick) tone_idx_r <= tone_idx_r + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Test state selection
    // ------------------------------------------------------------------
    wire logic rx_cut = opcond_r[BIT_RX_CUTOFF];
    wire logic fdl_act = (opcond_r[BIT_FD_LOOP] || impscale_r == IMPSCALE_FDL) && !rx_cut;
    wire logic loop_act = opcond_r[BIT_IF_LOOP] || opcond_r[BIT_SA_LOOP];
    wire logic [3:0] tq_k = tone_idx_r[3] ? 4'h8 - {1'b0, tone_idx_r[2:0]} : {1'b0, tone_idx_r[2:0]};
    wire logic signed [15:0] tone_mag = TONE_Q[tq_k];
    wire logic signed [15:0] tone_val = tone_idx_r[4] ? -tone_mag : tone_mag;
    wire logic signed [15:0] rx_src =
        rx_cut ? 16'sh0000 :
        opcond_r[BIT_TONE] ? tone_val : rx_pcm_in;
    wire logic signed [15:0] tx_in = fdl_act ? analog_out : analog_in;

    // ------------------------------------------------------------------
    // Serial CSD engine
    // ------------------------------------------------------------------
    cvf_eng_t eng_r;
    cvf_mul_t mul_r;
    logic [1:0] dig_r;
    logic [4:0] sh_r;
    logic sg_r;
    logic signed [DW-1:0] acc_r;
    logic signed [DW-1:0] p1_r;
    logic signed [15:0] rx_src_r, rx_prev_r, ry_r, s_r, zfb_r, hp_r, txin_prev_r, tx_fin_r;
    logic signed [15:0] analog_out_r;
    wire logic [15:0] z5 = {coef_r[0], coef_r[1]};
    wire logic [15:0] z6 = {8'h00, coef_r[2]};
    wire logic [15:0] z7 = {coef_r[3], coef_r[4]};
    wire logic signed [15:0] tx_pre = sat(sx(hp_r) + (fdl_act ? sx(16'sh0000) : sx(zfb_r)));
    wire logic [15:0] coef_w =
        mul_r == MUL_RXPOLE ? rxpole_r : mul_r == MUL_Z5 ? z5 :
        mul_r == MUL_Z7 ? z7 : mul_r == MUL_Z6 ? z6 : txgain_r;
    wire logic [2:0] ndig = mul_r == MUL_Z6 ? DIG_POST : DIG_FULL;
    wire logic signed [15:0] opnd =
        mul_r == MUL_RXPOLE ? ry_r : mul_r == MUL_Z5 ? ry_r :
        mul_r == MUL_Z7 ? s_r : mul_r == MUL_Z6 ? s_r : tx_pre;
    wire logic [3:0] nib = coef_w[{dig_r, 2'b00} +: 4];
    wire logic [4:0] sh_nxt = sh_r + {2'b00, nib[2:0]};
    wire logic sg_nxt = sg_r ^ nib[3];
    wire logic signed [DW-1:0] term = sx(opnd) >>> sh_nxt;
    wire logic signed [DW-1:0] acc_nxt = sg_nxt ? acc_r - term : acc_r + term;
    wire logic last_dig = {1'b0, dig_r} == ndig - 3'h1;
    wire logic signed [DW-1:0] rx_diff = sx(rx_src_r) - sx(rx_prev_r);
    wire logic signed [15:0] hp_nxt =
        opcond_r[BIT_HP_BYPASS] ? tx_in :
        sat(sx(tx_in) - sx(txin_prev_r) + sx(hp_r) - (sx(hp_r) >>> 5));
    wire logic signed [15:0] ry_nxt = sat(rx_diff + acc_nxt);
    wire logic signed [15:0] rx_outv = opcond_r[BIT_RX_GDROP] ? ry_nxt >>> 1 : ry_nxt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eng_r <= ENG_IDLE;
            mul_r <= MUL_RXPOLE;
            dig_r <= 2'h0;
            sh_r <= 5'h00;
            sg_r <= 1'b0;
            acc_r <= '0;
        end else begin
            case (eng_r)
                ENG_IDLE: begin
                    if (tick) eng_r <= ENG_RUN;
                end
                ENG_RUN: begin
                    if (last_dig) begin
                        dig_r <= 2'h0;
                        sh_r <= 5'h00;
                        sg_r <= 1'b0;
                        acc_r <= '0;
                        case (mul_r)
                            MUL_RXPOLE: mul_r <= MUL_Z5;
                            MUL_Z5: mul_r <= MUL_Z7;
                            MUL_Z7: mul_r <= MUL_Z6;
                            MUL_Z6: mul_r <= MUL_GX;
                            default: begin
                                mul_r <= MUL_RXPOLE;
                                eng_r <= ENG_IDLE;
                            end
                        endcase
                    end else begin
                        dig_r <= dig_r + 2'h1;
                        sh_r <= sh_nxt;
                        sg_r <= sg_nxt;
                        acc_r <= acc_nxt;
                    end
                end
                default: eng_r <= ENG_IDLE;
            endcase
        end
    end

    // Commit each product to the datapath node it feeds
    wire logic commit = eng_r == ENG_RUN && last_dig;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_src_r <= 16'sh0000;
            rx_prev_r <= 16'sh0000;
            ry_r <= 16'sh0000;
            s_r <= 16'sh0000;
            p1_r <= '0;
            zfb_r <= 16'sh0000;
            hp_r <= 16'sh0000;
            txin_prev_r <= 16'sh0000;
            tx_fin_r <= 16'sh0000;
            analog_out_r <= 16'sh0000;
        end else if (tick) begin
            rx_src_r <= rx_src;
            hp_r <= hp_nxt;
            txin_prev_r <= tx_in;
        end else if (commit) begin
            case (mul_r)
                MUL_RXPOLE: begin
                    ry_r <= ry_nxt;
                    rx_prev_r <= rx_src_r;
                    analog_out_r <= rx_outv;
                end
                // Scale gain 1/z6 is folded into z5 so the state keeps headroom
                MUL_Z5: p1_r <= acc_nxt;
                MUL_Z7: s_r <= sat(p1_r + acc_nxt);
                MUL_Z6: zfb_r <= sat(acc_nxt);
                default: tx_fin_r <= loop_act ? rx_src_r : sat(sx(tx_pre) + acc_nxt);
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Transmit slot and interrupt
    // ------------------------------------------------------------------
    logic strobe_n_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pcm_out_r <= 16'sh0000;
            strobe_n_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            if (tx_event) pcm_out_r <= tx_fin_r;
            strobe_n_r <= !tx_event;
            // A new sample in the read cycle keeps the flag raised
            if (tx_event && opcond_r[BIT_IRQ_ARM]) irq_r <= 1'b1;
            else if (rd_sample) irq_r <= 1'b0;
        end
    end

    assign analog_out = analog_out_r;
    assign analog_out_en = !fdl_act;
    assign pcm_transmit_out = pcm_out_r;
    assign pcm_transmit_out_oe = !tx_cut;
    assign transmit_slot_strobe_n = strobe_n_r;
    assign transmit_slot_strobe_oe = !tx_cut;
    assign tx_sample_irq = irq_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    tx_cut_hiz_a: assert property (tx_cut |-> !pcm_transmit_out_oe ##1 strobe_n_r)
        else $error("transmit cutoff did not float the output");
    irq_raise_a: assert property (tx_event && opcond_r[BIT_IRQ_ARM] |=> tx_sample_irq)
        else $error("armed sample did not raise interrupt");
    irq_clear_a: assert property (rd_sample && !tx_event |=> !tx_sample_irq)
        else $error("sample read did not clear interrupt");
    fdl_mute_a: assert property (impscale_r == IMPSCALE_FDL && !rx_cut |-> !analog_out_en)
        else $error("scaling code did not enter full loopback");
    tick_space_a: assert property (tick |=> !tick [*8])
        else $error("sample ticks too close");
    post_digits_a: assert property (eng_r == ENG_RUN && mul_r == MUL_Z6 |-> dig_r < 2'h2)
        else $error("scale factor used more than two digits");
    rx_cut_zero_a: assert property (tick && rx_cut |=> rx_src_r == 16'sh0000)
        else $error("receive cutoff did not zero receive");
    cmd_end_a: assert property (byte_step && cnt_r == LAST_BYTE |=> !cmd_act_r)
        else $error("command ran past five bytes");
    eng_len_a: assert property ($rose(eng_r == ENG_RUN) |-> ##[4:20] eng_r == ENG_IDLE)
        else $error("engine pass length out of range");
    strobe_pulse_a: assert property (tx_event |=> !transmit_slot_strobe_n ##1 transmit_slot_strobe_n)
        else $error("slot strobe not one cycle");

    write_cmd_c: cover property (wr_data && cnt_r == LAST_BYTE);
    read_cmd_c: cover property (rd_data && cnt_r == LAST_BYTE);
    irq_seen_c: cover property ($rose(tx_sample_irq));
    tone_fdl_c: cover property (opcond_r[BIT_TONE] && fdl_act && tick);

endmodule

/* verif/cvf_line_model.sv */
// Line-side sample source for the voice filter bench.
// Assumes the bench sets the level; samples change right after hclk edges.
`timescale 1ns/10ps
module cvf_line_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Level requested by the bench
    input wire logic signed [15:0] level,
    // Samples towards the block
    output logic signed [15:0] rx_pcm_in,
    output logic signed [15:0] analog_in
);
    // --------------------
    // Sample source
    // --------------------
    // Opposite polarity on the transmit input keeps the two paths distinguishable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_pcm_in <= 16'sh0000;
            analog_in <= 16'sh0000;
        end else begin
            rx_pcm_in <= level;
            analog_in <= -level;
        end
    end
endmodule

/* verif/tb_top.sv */
// Directed bench for the voice filter over AHB-Lite.
// Assumes no wait states and a sample tick every 3125 cycles.
`timescale 1ns/10ps
module tb_top
    import cvf_pkg::*;
;
    // --------------------
    // Signals
    // --------------------
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic signed [15:0] level, rx_pcm_in, analog_in, analog_out, pcm_transmit_out;
    logic analog_out_en, pcm_oe, strobe_n, strobe_oe, irq;
    logic [7:0] pat [5] = '{8'ha5, 8'h5a, 8'hc3, 8'h3c, 8'h81};
    int err_count, checks_done, seen;
    wire hready = hreadyout;

    cvf_voice_filter i_cvf_voice_filter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_pcm_in(rx_pcm_in), .analog_out(analog_out), .analog_out_en(analog_out_en),
        .analog_in(analog_in), .pcm_transmit_out(pcm_transmit_out),
        .pcm_transmit_out_oe(pcm_oe), .transmit_slot_strobe_n(strobe_n),
        .transmit_slot_strobe_oe(strobe_oe), .tx_sample_irq(irq));
    cvf_line_model i_cvf_line_model (.hclk(hclk), .hresetn(hresetn), .level(level),
        .rx_pcm_in(rx_pcm_in), .analog_in(analog_in));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // --------------------
    // Tasks
    // --------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // Single transfer; waits on hready so no latency is assumed
    task automatic xfer(input logic w, input logic [31:0] addr, input logic [31:0] data,
                        input logic [2:0] size);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= w;
        hsize <= size;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? data : 32'h0;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        xfer(1'b1, {24'h0, addr}, data, 3'h2);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        xfer(1'b0, {24'h0, addr}, 32'h0, 3'h2);
        chk(name, exp, rd);
    endtask
    task automatic wait_bit(input int sel, input logic lvl, input int limit);
        logic v;
        v = ~lvl;
        for (int n = 0; n < limit && v !== lvl; n++) begin
            @(posedge hclk);
            v = (sel == 0) ? strobe_n : irq;
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // --------------------
    // Tests
    // --------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        level = 16'sh03e8;
        err_count = 0;
        checks_done = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        chk("strobe idle", 32'h1, {31'h0, strobe_n});
        chk("enables", 32'h7, {28'h0, hresp, analog_out_en, pcm_oe, strobe_oe});
        rd_chk("opcond", ADDR_OPCOND, 32'h0);
        rd_chk("rx pole", ADDR_RXPOLE, {16'h0, RST_COEF});
        rd_chk("tx gain", ADDR_TXGAIN, {16'h0, RST_COEF});
        wr(ADDR_OPCOND, (32'h1 << BIT_RX_CUTOFF) | (32'h1 << BIT_TONE));
        repeat (6400) @(posedge hclk);
        chk("cutoff output", 32'h0, {16'h0, analog_out});
        wr(ADDR_OPCOND, 32'h0);
        wr(ADDR_CMD, 32'h9b);
        rd_chk("command", ADDR_CMD, 32'h9b);
        for (int i = 0; i < 5; i++) begin
            rd_chk("reset byte", ADDR_DATA, {24'h0, RST_BYTES[39-8*i -: 8]});
        end
        wr(ADDR_CMD, 32'h9a);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_DATA, {24'h0, pat[i]});
        end
        wr(ADDR_CMD, 32'h9b);
        for (int i = 0; i < 5; i++) begin
            rd_chk("stored byte", ADDR_DATA, {24'h0, pat[i]});
        end
        rd_chk("data after end", ADDR_DATA, 32'h0);
        xfer(1'b0, 32'h100, 32'h0, 3'h2);
        chk("unmapped", 32'h0, rd);
        xfer(1'b1, 32'h100, 32'h1ff, 3'h2);
        xfer(1'b1, 32'h0, 32'h1ff, 3'h1);
        rd_chk("ignored writes", ADDR_OPCOND, 32'h0);
        wr(ADDR_OPCOND, 32'h1ff);
        rd_chk("controls", ADDR_OPCOND, 32'h1ff);
        wr(ADDR_OPCOND, 32'h1 << BIT_FD_LOOP);
        @(posedge hclk);
        chk("loopback out", 32'h0, {31'h0, analog_out_en});
        wr(ADDR_OPCOND, 32'h0);
        wr(ADDR_IMPSCALE, {27'h0, IMPSCALE_FDL});
        @(posedge hclk);
        chk("scaling loopback", 32'h0, {31'h0, analog_out_en});
        wr(ADDR_IMPSCALE, 32'h0);
        @(posedge hclk);
        chk("out restored", 32'h1, {31'h0, analog_out_en});
        wr(ADDR_OPCOND, (32'h1 << BIT_IRQ_ARM) | (32'h1 << BIT_IF_LOOP));
        wait_bit(0, 1'b0, 13000);
        chk("slot strobe", 32'h0, {31'h0, strobe_n});
        @(posedge hclk);
        chk("strobe width", 32'h1, {31'h0, strobe_n});
        wait_bit(1, 1'b1, 4);
        chk("sample irq", 32'h1, {31'h0, irq});
        xfer(1'b0, {24'h0, ADDR_TXSAMPLE}, 32'h0, 3'h2);
        chk("irq after read", 32'h0, {31'h0, irq});
        wait_bit(0, 1'b0, 13000);
        chk("looped sample", {16'h0, level}, {16'h0, pcm_transmit_out});
        chk("irq again", 32'h1, {31'h0, irq});
        rd_chk("read sample", ADDR_TXSAMPLE, {16'h0, level});
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(ADDR_OPCOND, (32'h1 << BIT_TX_CUTOFF) | (32'h1 << BIT_IRQ_ARM));
        @(posedge hclk);
        chk("cutoff enables", 32'h0, {30'h0, pcm_oe, strobe_oe});
        seen = 0;
        repeat (13000) begin
            @(posedge hclk);
            seen += (strobe_n === 1'b0 || irq === 1'b1) ? 1 : 0;
        end
        chk("suppressed slot", 32'h0, 32'(seen));
        conclude();
    end

    // Tests need about 40000 cycles; a hang is cut at 50000
    initial begin
        repeat (50000) @(posedge hclk);
        err_count++;
        $display("unexpected watchdog: expected finish, seen timeout");
        conclude();
    end
endmodule
